// ===== dv/spc_nv_model.sv
// Behavioural model of the nonvolatile register area read port.
// Assumes the controller reads one word per cycle with nv_rd_en high.
`timescale 1ns/1ns

module spc_nv_model (
   // Read port
   input  wire logic [3:0] nv_rd_addr,
   input  wire logic       nv_rd_en,
   output logic      [7:0] nv_rd_data
);
   // ----------------------------------------------------------------
   // Array contents
   // ----------------------------------------------------------------
   logic [7:0] last_reg;
   // Fixed contents, never written: the array stays intact
   always_comb begin
      if (nv_rd_en) begin
         nv_rd_data = {4'h5, nv_rd_addr};
      end else begin
         nv_rd_data = ~last_reg; // Not selected: no stale value shown
      end
   end
   // Remember last word driven so idle shows its inverse
   always @(nv_rd_data) if (nv_rd_en) last_reg = nv_rd_data;
   initial last_reg = 8'h00;
endmodule // spc_nv_model

// ===== dv/spc_stop_ctrl_assertions.sv
// Concurrent checks on the stop-mode controller's ports.
// Assumes one clock domain and the reset of the design's top module.
`timescale 1ns/1ns

module spc_stop_ctrl_assertions #(
   parameter int unsigned      PIN_W        = 8,
   parameter logic [PIN_W-1:0] PIN_RST_OUT  = '0,
   parameter logic [PIN_W-1:0] PIN_RST_OE_N = '1
) (
   // Clock, reset, enable
   input  wire logic                         clock,
   input  wire logic                         nrst,
   input  wire logic                         clk_en,
   // Requests and configuration from the CPU
   input  wire logic                         stop_req,
   input  wire spc_pkg::spc_depth_e          stop_depth_sel,
   input  wire logic                         osc_keep_run,
   input  wire logic                         ref_keep_run,
   input  wire logic                         low_voltage_detect_stop_en,
   input  wire logic                         background_debug_mode_en,
   input  wire logic                         power_down_ack,
   input  wire logic                         wake_irq,
   // Pads
   input  wire logic [PIN_W-1:0]             pin_out,
   input  wire logic [PIN_W-1:0]             pin_oe_n,
   input  wire logic                         pins_latched,
   // Clock generator
   input  wire logic                         clock_generator_standby,
   input  wire logic                         clock_generator_off,
   input  wire logic                         osc_run,
   input  wire logic                         ref_run,
   // Peripheral clocks and resets
   input  wire logic [spc_pkg::SPC_NPER-1:0] periph_clk_en,
   input  wire logic [spc_pkg::SPC_NPER-1:0] periph_rst_n,
   input  wire logic                         adc_standby,
   input  wire logic                         adc_rst_n,
   input  wire logic                         kbi_enable,
   input  wire logic                         kbi_rst_n,
   // Core, memories, regulator, status
   input  wire logic                         core_reg_rst,
   input  wire logic                         ram_retain,
   input  wire logic                         flash_wr_lock,
   input  wire logic                         vreg_standby,
   input  wire logic                         stopped
);
   import spc_pkg::*;
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // Wake hold window is excluded: clocks come back during it
   AST_STOP_GATE: assert property (stopped && !core_reg_rst |->
      periph_clk_en == '0 && adc_standby && flash_wr_lock)
      else $error("peripheral gating wrong while stopped");
   AST_CG_OFF: assert property (stopped && clock_generator_off |->
      !osc_run && !ref_run) else $error("oscillator runs with cg off");
   AST_LIGHT_CG: assert property ($rose(stopped) &&
      $past(stop_depth_sel) inside {SPC_DEPTH_LIGHT, SPC_DEPTH_NONE} |->
      clock_generator_standby && !clock_generator_off &&
      osc_run == $past(osc_keep_run) && ref_run == $past(ref_keep_run))
      else $error("light stop clock state wrong");
   AST_VREG: assert property ($rose(stopped) |-> vreg_standby ==
      !($past(low_voltage_detect_stop_en) || $past(background_debug_mode_en)))
      else $error("regulator standby wrong");
   AST_PADS_HOLD: assert property (stopped && $past(stopped) &&
      ram_retain && !core_reg_rst |-> $stable(pin_out) && $stable(pin_oe_n))
      else $error("pads moved while stopped");
   AST_DEEP_PADS: assert property (stopped && !ram_retain &&
      !core_reg_rst |-> pin_out == PIN_RST_OUT && pin_oe_n == PIN_RST_OE_N)
      else $error("deep stop pads not at reset values");
   AST_WAKE_RST: assert property ($rose(core_reg_rst) |->
      (core_reg_rst && periph_rst_n == '0 && !adc_rst_n && !kbi_rst_n)[*4]
      ##1 !core_reg_rst) else $error("wake reset hold wrong");
   AST_KBI_OFF: assert property (stopped && clock_generator_off |->
      !kbi_enable) else $error("keyboard enabled in deep stop");
   // A partial stop taken in the same cycle latches the pads again
   AST_ACK: assert property (clk_en && pins_latched && !stopped &&
      power_down_ack && !stop_req |=> !pins_latched)
      else $error("ack did not release");
   C_LIGHT: cover property ($rose(stopped) && clock_generator_standby);
   C_OFF: cover property ($rose(stopped) && clock_generator_off);
   C_ACK: cover property ($fell(pins_latched));
endmodule // spc_stop_ctrl_assertions

bind spc_stop_ctrl spc_stop_ctrl_assertions #(.PIN_W(PIN_W),
   .PIN_RST_OUT(PIN_RST_OUT), .PIN_RST_OE_N(PIN_RST_OE_N)) chk_i (.*);

// ===== dv/spc_stop_ctrl_bench.sv
// Self-checking bench for the stop-mode controller.
// Assumes default parameters and the nonvolatile model beside it.
`timescale 1ns/1ns

module spc_stop_ctrl_bench;
   import spc_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clock = 0, nrst = 0, stop_req = 0, ack = 0, wake = 0, keyboard_interrupt_module = 0;
   logic osc_k = 0, ref_k = 0, low_voltage_detect = 0, background_debug_mode = 0, ce = 1;
   spc_depth_e sel = SPC_DEPTH_LIGHT;
   logic [7:0] p_in = 8'h5a, oe_in = 8'h0f, nv_d, c0, c1, c2, p_o, p_oe;
   logic [3:0] nv_a;
   logic [5:0] pce, prn;
   logic nv_e, lat, cgs, cgo, osr, rfr, ads, adr, kbe, kbr, crr, rr, fl;
   logic vs, st;
   int n_mismatch = 0, total_checks = 0, cyc = 0;

   spc_nv_model spc_nv_model_i (.nv_rd_addr(nv_a), .nv_rd_en(nv_e),
      .nv_rd_data(nv_d));
   spc_stop_ctrl spc_stop_ctrl_i (.clock(clock), .nrst(nrst), .clk_en(ce),
      .stop_req(stop_req), .stop_depth_sel(sel), .osc_keep_run(osc_k),
      .ref_keep_run(ref_k), .low_voltage_detect_stop_en(low_voltage_detect),
      .background_debug_mode_en(background_debug_mode), .power_down_ack(ack),
      .wake_irq(wake), .kbi_event(keyboard_interrupt_module), .pin_out_in(p_in),
      .pin_oe_n_in(oe_in), .nv_rd_data(nv_d), .nv_rd_addr(nv_a),
      .nv_rd_en(nv_e), .cfg_val0(c0), .cfg_val1(c1), .cfg_val2(c2),
      .pin_out(p_o), .pin_oe_n(p_oe), .pins_latched(lat),
      .clock_generator_standby(cgs), .clock_generator_off(cgo),
      .osc_run(osr), .ref_run(rfr), .periph_clk_en(pce),
      .periph_rst_n(prn), .adc_standby(ads), .adc_rst_n(adr),
      .kbi_enable(kbe), .kbi_rst_n(kbr), .core_reg_rst(crr),
      .ram_retain(rr), .flash_wr_lock(fl), .vreg_standby(vs), .stopped(st));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial forever #50 clock = ~clock;
   // Inputs change 10 ns after the edge, once its updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #10;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   // One-cycle request pulse on stop_req
   task automatic enter(input spc_depth_e d);
      sel = d;
      stop_req = 1;
      tick(1);
      stop_req = 0;
   endtask
   task automatic finish_test;
      $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc > 2000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_load;
      tick(1);
      chk("nv rd", 5'h10, {nv_e, nv_a});
      tick(3);
      chk("cfg", 24'h505152, {c0, c1, c2});
      chk("nv idle", 1'b0, nv_e);
   endtask
   task automatic t_light;
      osc_k = 1;
      tick(1);
      enter(SPC_DEPTH_NONE);
      p_in = 8'ha5;
      tick(2);
      chk("pads", 16'h5a0f, {p_o, p_oe});
      chk("cg", 4'b1010, {cgs, cgo, osr, rfr});
      chk("gate", 6'h00, pce);
      chk("misc", 5'b11111, {ads, vs, kbe, rr, fl});
      // Frozen enable: the keyboard event must wait for it
      ce = 0;
      keyboard_interrupt_module = 1;
      tick(1);
      chk("frozen", 1'b1, st);
      ce = 1;
      tick(1);
      keyboard_interrupt_module = 0;
      chk("woke", 2'b00, {st, crr});
      tick(1);
      chk("run pads", 16'ha50f, {p_o, p_oe});
      // Explicit light code, woken by the interrupt line
      enter(SPC_DEPTH_LIGHT);
      chk("light", 3'b110, {st, cgs, cgo});
      wake = 1;
      tick(1);
      wake = 0;
      chk("irq woke", 17'h0a50f, {st, p_o, p_oe});
   endtask
   task automatic t_partial;
      low_voltage_detect = 1;
      enter(SPC_DEPTH_PARTIAL);
      p_in = 8'h3c;
      oe_in = 8'h00;
      keyboard_interrupt_module = 1;
      tick(2);
      keyboard_interrupt_module = 0;
      chk("latched", 5'b11100, {st, lat, cgo, osr, rfr});
      chk("kbi vreg", 2'b00, {kbe, vs});
      wake = 1;
      tick(1);
      wake = 0;
      chk("rst", 9'h100, {crr, prn, adr, kbr});
      tick(4);
      chk("held", 19'h1a50f, {st, lat, p_o, p_oe});
      chk("rel", 10'h1ff, {crr, rr, prn, adr, kbr});
      ack = 1;
      tick(1);
      ack = 0;
      tick(1);
      chk("ack", 17'h03c00, {lat, p_o, p_oe});
      low_voltage_detect = 0;
   endtask
   task automatic t_deep;
      background_debug_mode = 1;
      osc_k = 1;
      ref_k = 1;
      enter(SPC_DEPTH_DEEP);
      tick(1);
      chk("deep", 20'h800ff, {st, rr, vs, osr, p_o, p_oe});
      wake = 1;
      tick(1);
      wake = 0;
      tick(4);
      chk("after", 3'b001, {st, crr, rr});
   endtask

   initial begin
      tick(4);
      nrst = 1;
      t_load();
      t_light();
      t_partial();
      t_deep();
      finish_test();
   end
endmodule // spc_stop_ctrl_bench

// ===== rtl/spc_pkg.sv
// Constants and types shared by the stop-mode power controller.
// Assumes a single system clock and an active-low asynchronous reset.
package spc_pkg;

   // ----------------------------------------------------------------
   // Stop depth selection, as written by software
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SPC_DEPTH_NONE    = 2'h0,  // Treated as light stop
      SPC_DEPTH_DEEP    = 2'h1,
      SPC_DEPTH_PARTIAL = 2'h2,
      SPC_DEPTH_LIGHT   = 2'h3
   } spc_depth_e;

   // ----------------------------------------------------------------
   // Gated peripheral slots
   // ----------------------------------------------------------------
   localparam int unsigned SPC_NPER   = 6;
   localparam int unsigned SPC_P_TMR1 = 0;
   localparam int unsigned SPC_P_TMR2 = 1;
   localparam int unsigned SPC_P_SER1 = 2;
   localparam int unsigned SPC_P_SER2 = 3;
   localparam int unsigned SPC_P_SPI  = 4;
   localparam int unsigned SPC_P_TWB  = 5;

   // ----------------------------------------------------------------
   // Nonvolatile register area layout (16 locations)
   // ----------------------------------------------------------------
   localparam logic [3:0] SPC_NV_CFG_BASE = 4'h0;  // Three config values
   localparam logic [1:0] SPC_NV_CFG_N    = 2'h3;
   localparam logic [3:0] SPC_NV_KEY_BASE = 4'h8;  // Eight key bytes

   // ----------------------------------------------------------------
   // Timing and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] SPC_WAKE_RST_CYC = 3'h4; // Reset hold on wake
   localparam logic [7:0] SPC_CFG_RST      = 8'h00;

endpackage

// ===== rtl/spc_stop_ctrl.sv
// Stop-mode power controller: entry and wake-up actions for three stop
// depths, plus the reset-time copy of nonvolatile configuration.
// Assumes the nonvolatile array answers combinationally in the cycle
// its address is presented, and that all inputs are clock-synchronous.
`timescale 1ns/1ns

module spc_stop_ctrl #(
   parameter int unsigned PIN_W       = 8,
   parameter logic [PIN_W-1:0] PIN_RST_OUT  = '0,
   parameter logic [PIN_W-1:0] PIN_RST_OE_N = '1
) (
   // Clock, reset, enable
   input  wire logic                    clock,
   input  wire logic                    nrst,
   input  wire logic                    clk_en,
   // Requests and configuration from the CPU
   input  wire logic                    stop_req,
   input  wire spc_pkg::spc_depth_e     stop_depth_sel,
   input  wire logic                    osc_keep_run,
   input  wire logic                    ref_keep_run,
   input  wire logic                    low_voltage_detect_stop_en,
   input  wire logic                    background_debug_mode_en,
   input  wire logic                    power_down_ack,
   // Wake sources
   input  wire logic                    wake_irq,
   input  wire logic                    kbi_event,
   // Pin values wanted by the port logic
   input  wire logic [PIN_W-1:0]        pin_out_in,
   input  wire logic [PIN_W-1:0]        pin_oe_n_in,
   // Nonvolatile area read port
   input  wire logic [7:0]              nv_rd_data,
   output logic      [3:0]              nv_rd_addr,
   output logic                         nv_rd_en,
   // Working copies of the nonvolatile configuration
   output logic      [7:0]              cfg_val0,
   output logic      [7:0]              cfg_val1,
   output logic      [7:0]              cfg_val2,
   // Pads
   output logic      [PIN_W-1:0]        pin_out,
   output logic      [PIN_W-1:0]        pin_oe_n,
   output logic                         pins_latched,
   // Clock generator
   output logic                         clock_generator_standby,
   output logic                         clock_generator_off,
   output logic                         osc_run,
   output logic                         ref_run,
   // Peripheral clocks and resets
   output logic [spc_pkg::SPC_NPER-1:0] periph_clk_en,
   output logic [spc_pkg::SPC_NPER-1:0] periph_rst_n,
   output logic                         adc_standby,
   output logic                         adc_rst_n,
   output logic                         kbi_enable,
   output logic                         kbi_rst_n,
   // Core, memories, regulator, status
   output logic                         core_reg_rst,
   output logic                         ram_retain,
   output logic                         flash_wr_lock,
   output logic                         vreg_standby,
   output logic                         stopped
);
   import spc_pkg::*;
   // Flow: LOAD copies configuration once after reset, RUN tracks the
   // pads, STOP holds the chosen depth, WAKE stretches the reset that
   // a deeper depth needs on the way out. A light wake skips WAKE.

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SPC_LOAD,
      SPC_RUN,
      SPC_STOP,
      SPC_WAKE
   } spc_state_e;

   // Every piece of state lives in this one record, so a low clock
   // enable freezes it all at once with no stragglers.
   typedef struct packed {
      spc_state_e          state;
      spc_depth_e          depth;
      logic [1:0]          idx;
      logic [2:0]          cnt;
      logic [3:0]          nv_addr;
      logic                nv_rd;
      logic [2:0][7:0]     cfg;
      logic [PIN_W-1:0]    pin_out;
      logic [PIN_W-1:0]    pin_oe_n;
      logic                held;
      logic                cg_standby;
      logic                cg_off;
      logic                osc_run;
      logic                ref_run;
      logic [SPC_NPER-1:0] pclk;
      logic [SPC_NPER-1:0] prst_n;
      logic                adc_standby;
      logic                adc_rst_n;
      logic                kbi_en;
      logic                kbi_rst_n;
      logic                reg_rst;
      logic                ram_keep;
      logic                flash_lock;
      logic                vreg_lp;
      logic                stopped;
   } spc_state_s;

   spc_state_s r_reg;
   spc_state_s r_next;

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   // Unprogrammed depth falls back to the shallowest, safest depth
   function automatic logic spc_is_light(input spc_depth_e d);
      spc_is_light = (d == SPC_DEPTH_LIGHT) || (d == SPC_DEPTH_NONE);
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      r_next       = r_reg;
      r_next.nv_rd = 1'b0;
      unique case (r_reg.state)
         // Copy configuration words, one per cycle
         SPC_LOAD: begin
            // First pass only sets the address; data follows a cycle on
            if (r_reg.idx != 2'h0) begin
               r_next.cfg[r_reg.idx - 2'h1] = nv_rd_data;
            end
            if (r_reg.idx == SPC_NV_CFG_N) begin
               r_next.state = SPC_RUN;
            end else begin
               r_next.nv_rd   = 1'b1;
               r_next.nv_addr = SPC_NV_CFG_BASE + {2'h0, r_reg.idx};
               r_next.idx     = r_reg.idx + 2'h1;
            end
         end
         SPC_RUN: begin
            // Latched pads stay frozen until software acknowledges
            if (r_reg.held && power_down_ack) begin
               r_next.held = 1'b0;
            end
            if (!r_reg.held || power_down_ack) begin
               r_next.pin_out  = pin_out_in;
               r_next.pin_oe_n = pin_oe_n_in;
            end
            // A request is taken only here; it is ignored while loading
            // or while already stopped.
            if (stop_req) begin
               r_next.state       = SPC_STOP;
               r_next.depth       = stop_depth_sel;
               r_next.stopped     = 1'b1;
               r_next.pclk        = '0;
               r_next.adc_standby = 1'b1;
               r_next.flash_lock  = 1'b1;
               r_next.vreg_lp     = !(low_voltage_detect_stop_en ||
                                      background_debug_mode_en);
               // Pads keep the value registered before the request; deep stop loads the reset values instead
               r_next.pin_out  = r_reg.pin_out;
               r_next.pin_oe_n = r_reg.pin_oe_n;
               if (spc_is_light(stop_depth_sel)) begin
                  r_next.cg_standby = 1'b1;
                  r_next.osc_run    = osc_keep_run;
                  r_next.ref_run    = ref_keep_run;
                  r_next.ram_keep   = 1'b1;
               end else begin
                  r_next.cg_off  = 1'b1;
                  r_next.osc_run = 1'b0;
                  r_next.ref_run = 1'b0;
                  r_next.kbi_en  = 1'b0;
                  if (stop_depth_sel == SPC_DEPTH_PARTIAL) begin
                     r_next.held     = 1'b1;
                     r_next.ram_keep = 1'b1;
                  end else begin
                     r_next.pin_out  = PIN_RST_OUT;
                     r_next.pin_oe_n = PIN_RST_OE_N;
                     r_next.held     = 1'b0;
                     r_next.ram_keep = 1'b0;
                  end
               end
            end
         end
         SPC_STOP: begin
            if (spc_is_light(r_reg.depth)) begin
               // Registers untouched, so resume where we left off
               if (wake_irq || (r_reg.kbi_en && kbi_event)) begin
                  r_next.state       = SPC_RUN;
                  r_next.stopped     = 1'b0;
                  r_next.pclk        = '1;
                  r_next.adc_standby = 1'b0;
                  r_next.cg_standby  = 1'b0;
                  r_next.osc_run     = 1'b1;
                  r_next.ref_run     = 1'b1;
                  r_next.vreg_lp     = 1'b0;
                  r_next.flash_lock  = 1'b0;
               end
            end else if (wake_irq) begin
               // Keyboard events cannot end this depth: module is off
               // Deeper wake: core, peripherals, ADC and keyboard restart from reset
               r_next.state       = SPC_WAKE;
               r_next.cnt         = 3'h0;
               r_next.reg_rst     = 1'b1;
               r_next.prst_n      = '0;
               r_next.adc_rst_n   = 1'b0;
               r_next.kbi_rst_n   = 1'b0;
               r_next.pclk        = '1;
               r_next.adc_standby = 1'b0;
               r_next.cg_off      = 1'b0;
               r_next.osc_run     = 1'b1;
               r_next.ref_run     = 1'b1;
               r_next.vreg_lp     = 1'b0;
            end
         end
         SPC_WAKE: begin
            // Peripherals see reset for the whole counted span
            r_next.cnt = r_reg.cnt + 3'h1;
            if (r_reg.cnt == SPC_WAKE_RST_CYC - 3'h1) begin
               r_next.state      = SPC_RUN;
               r_next.stopped    = 1'b0;
               r_next.reg_rst    = 1'b0;
               r_next.prst_n     = '1;
               r_next.adc_rst_n  = 1'b1;
               r_next.kbi_rst_n  = 1'b1;
               r_next.kbi_en     = 1'b1;
               r_next.ram_keep   = 1'b1;
               r_next.flash_lock = 1'b0;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register; reset loads constants only
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         r_reg           <= '0;
         r_reg.state     <= SPC_LOAD;
         r_reg.depth     <= SPC_DEPTH_NONE;
         r_reg.cfg       <= {3{SPC_CFG_RST}};
         r_reg.pin_out   <= PIN_RST_OUT;
         r_reg.pin_oe_n  <= PIN_RST_OE_N;
         r_reg.osc_run   <= 1'b1;
         r_reg.ref_run   <= 1'b1;
         r_reg.pclk      <= '1;
         r_reg.prst_n    <= '1;
         r_reg.adc_rst_n <= 1'b1;
         r_reg.kbi_en    <= 1'b1;
         r_reg.kbi_rst_n <= 1'b1;
         r_reg.ram_keep  <= 1'b1;
      end else if (clk_en) begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------
   // No logic between flops and pins, so pads never glitch on a
   // decode change.
   assign nv_rd_addr              = r_reg.nv_addr;
   assign nv_rd_en                = r_reg.nv_rd;
   assign cfg_val0                = r_reg.cfg[0];
   assign cfg_val1                = r_reg.cfg[1];
   assign cfg_val2                = r_reg.cfg[2];
   assign pin_out                 = r_reg.pin_out;
   assign pin_oe_n                = r_reg.pin_oe_n;
   assign pins_latched            = r_reg.held;
   assign clock_generator_standby = r_reg.cg_standby;
   assign clock_generator_off     = r_reg.cg_off;
   assign osc_run                 = r_reg.osc_run;
   assign ref_run                 = r_reg.ref_run;
   assign periph_clk_en           = r_reg.pclk;
   assign periph_rst_n            = r_reg.prst_n;
   assign adc_standby             = r_reg.adc_standby;
   assign adc_rst_n               = r_reg.adc_rst_n;
   assign kbi_enable              = r_reg.kbi_en;
   assign kbi_rst_n               = r_reg.kbi_rst_n;
   assign core_reg_rst            = r_reg.reg_rst;
   assign ram_retain              = r_reg.ram_keep;
   assign flash_wr_lock           = r_reg.flash_lock;
   assign vreg_standby            = r_reg.vreg_lp;
   assign stopped                 = r_reg.stopped;

endmodule // spc_stop_ctrl
